//--- hdl/ppc_port.sv
/*
 * ppc_port: three 8-bit parallel ports with mode 1 / mode 2 handshake,
 * port C status view, command-write clearing of the port A and C output latches and a pulse reset pin.
 * assumes a classic Wishbone master on REF_CLK and pins asynchronous to it.
 */
module ppc_port
    import ppc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [PPC_AW-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [7:0] PA_I,
    output logic [7:0] PA_O,
    output logic [7:0] PA_OE,
    input wire logic [7:0] PB_I,
    output logic [7:0] PB_O,
    output logic [7:0] PB_OE,
    input wire logic [7:0] PC_I,
    output logic [7:0] PC_O,
    output logic [7:0] PC_OE,
    input wire logic PORT_RESET,
    output logic IRQ
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] out_a;
        logic [7:0] out_b;
        logic [7:0] out_c;
        logic [7:0] in_a;
        logic [7:0] in_b;
        logic group_a_input_full;
        logic group_a_output_full_n;
        logic group_b_input_full;
        logic group_b_output_full_n;
        logic group_a_irq_enable;
        logic bidir_output_irq_enable;
        logic group_b_irq_enable;
        logic group_a_irq_request;
        logic group_b_irq_request;
        logic [7:0] pc_q;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        logic irq;
        logic ack;
        logic [31:0] dat;
        logic [6:0] rst_cnt;
        logic [7:0] pa_o;
        logic [7:0] pa_oe;
        logic [7:0] pb_o;
        logic [7:0] pb_oe;
        logic [7:0] pc_o;
        logic [7:0] pc_oe;
    } ppc_state_t;

    ppc_state_t st_ff;
    ppc_state_t nxt_st;
    logic [24:0] pins;
    logic [7:0] pa_s;
    logic [7:0] pb_s;
    logic [7:0] pc_s;
    logic reset_pin;

    ppc_sync3 u_sync (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .d({PORT_RESET, PC_I, PB_I, PA_I}),
        .q(pins)
    );

    assign pa_s = pins[7:0];
    assign pb_s = pins[15:8];
    assign pc_s = pins[23:16];
    assign reset_pin = pins[24];

    function automatic logic fell(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction : fell

    function automatic logic [7:0] mask8(input logic [7:0] d, input logic [3:0] sel);
        return sel[0] ? d : 8'h00;
    endfunction : mask8

    // status view of port C; io positions show pins
    function automatic logic [7:0] status_view(input ppc_state_t s, input logic [7:0] pc);
        logic [7:0] v;
        v = pc;
        if (s.mode[PPC_GA_M2]) begin
            v[7] = s.group_a_output_full_n;
            v[6] = s.bidir_output_irq_enable;
            v[5] = s.group_a_input_full;
            v[4] = s.group_a_irq_enable;
            v[3] = s.group_a_irq_request;
        end else if (s.mode[PPC_GA_M1]) begin
            if (s.mode[PPC_PA_IN]) begin
                v[5] = s.group_a_input_full;
                v[4] = s.group_a_irq_enable;
            end else begin
                v[7] = s.group_a_output_full_n;
                v[6] = s.bidir_output_irq_enable;
            end
            v[3] = s.group_a_irq_request;
        end
        if (s.mode[PPC_GB_M1]) begin
            v[2] = s.group_b_irq_enable;
            if (s.mode[PPC_PB_IN]) begin
                v[1] = s.group_b_input_full;
            end else begin
                v[1] = s.group_b_output_full_n;
            end
            v[0] = s.group_b_irq_request;
        end
        return v;
    endfunction : status_view

    logic a_m2;
    logic a_m1;
    logic a_hs;
    logic a_in;
    logic b_m1;
    logic b_in;
    logic strobe_a_fell;
    logic ack_a_fell;
    logic strobe_b_fell;
    logic ack_b_fell;
    logic req;
    logic wr;
    logic rd;
    logic [7:0] input_strobe_n_a;
    logic [7:0] wd;

    always_comb begin
        nxt_st = st_ff;
        a_m2 = st_ff.mode[PPC_GA_M2];
        a_m1 = ~a_m2 & st_ff.mode[PPC_GA_M1];
        a_hs = a_m1 | a_m2;
        a_in = st_ff.mode[PPC_PA_IN];
        b_m1 = st_ff.mode[PPC_GB_M1];
        b_in = st_ff.mode[PPC_PB_IN];
        input_strobe_n_a = pc_s;
        nxt_st.pc_q = pc_s;
        strobe_a_fell = fell(st_ff.pc_q[PPC_PC_STROBE_A], pc_s[PPC_PC_STROBE_A]);
        ack_a_fell = fell(st_ff.pc_q[PPC_PC_ACK_A], pc_s[PPC_PC_ACK_A]);
        strobe_b_fell = fell(st_ff.pc_q[PPC_PC_HS_B], pc_s[PPC_PC_HS_B]) & b_in;
        ack_b_fell = fell(st_ff.pc_q[PPC_PC_HS_B], pc_s[PPC_PC_HS_B]) & ~b_in;
        req = WB_CYC_I & WB_STB_I & ~st_ff.ack;
        wr = req & WB_WE_I;
        rd = req & ~WB_WE_I;
        wd = mask8(WB_DAT_I[7:0], WB_SEL_I);
        nxt_st.ack = req;

        // clears first, so a same-cycle set below wins
        if (rd && WB_ADR_I == PPC_ADR_PORT_A && (a_m2 || (a_m1 && a_in))) begin
            nxt_st.group_a_input_full = 1'b0;
        end
        if (rd && WB_ADR_I == PPC_ADR_PORT_B && b_m1 && b_in) begin
            nxt_st.group_b_input_full = 1'b0;
        end
        if ((a_m2 || (a_m1 && !a_in)) && ack_a_fell) begin
            nxt_st.group_a_output_full_n = 1'b1;
        end
        if (b_m1 && ack_b_fell) begin
            nxt_st.group_b_output_full_n = 1'b1;
        end
        if ((a_m2 || (a_m1 && a_in)) && strobe_a_fell) begin
            nxt_st.group_a_input_full = 1'b1;
            nxt_st.in_a = pa_s;
        end
        if (b_m1 && strobe_b_fell) begin
            nxt_st.group_b_input_full = 1'b1;
            nxt_st.in_b = pb_s;
        end

        nxt_st.dat = 32'h0000_0000;
        if (rd) begin
            unique case (WB_ADR_I)
                PPC_ADR_PORT_A: nxt_st.dat[7:0] = a_hs ? st_ff.in_a : (a_in ? pa_s : st_ff.out_a);
                PPC_ADR_PORT_B: nxt_st.dat[7:0] = b_m1 ? st_ff.in_b : (b_in ? pb_s : st_ff.out_b);
                PPC_ADR_PORT_C: nxt_st.dat[7:0] = status_view(st_ff, pc_s);
                PPC_ADR_CMD: nxt_st.dat[7:0] = st_ff.mode;
                PPC_ADR_IRQ_STAT: nxt_st.dat[1:0] = st_ff.irq_stat;
                PPC_ADR_IRQ_EN: nxt_st.dat[1:0] = st_ff.irq_en;
                default: nxt_st.dat = 32'h0000_0000;
            endcase
        end

        if (wr && WB_SEL_I[0]) begin
            unique case (WB_ADR_I)
                PPC_ADR_PORT_A: begin
                    nxt_st.out_a = wd;
                    if (a_m2 || (a_m1 && !a_in)) begin
                        nxt_st.group_a_output_full_n = 1'b0;
                    end
                end
                PPC_ADR_PORT_B: begin
                    nxt_st.out_b = wd;
                    if (b_m1 && !b_in) begin
                        nxt_st.group_b_output_full_n = 1'b0;
                    end
                end
                PPC_ADR_PORT_C: nxt_st.out_c = wd;
                PPC_ADR_CMD: begin
                    if (wd[PPC_CMD_SEL]) begin
                        nxt_st.mode = wd;
                        nxt_st.out_a = 8'h00;
                        nxt_st.out_c = 8'h00;
                        // out_b kept on purpose: drives stale data until rewritten
                        nxt_st.group_a_input_full = 1'b0;
                        nxt_st.group_b_input_full = 1'b0;
                        nxt_st.group_a_output_full_n = 1'b1;
                        nxt_st.group_b_output_full_n = 1'b1;
                        nxt_st.group_a_irq_enable = 1'b0;
                        nxt_st.bidir_output_irq_enable = 1'b0;
                        nxt_st.group_b_irq_enable = 1'b0;
                    end else begin
                        // bit set/reset; enable flops sit on the handshake input pins
                        nxt_st.out_c[wd[3:1]] = wd[0];
                        if (wd[3:1] == 3'(PPC_PC_STROBE_A)) begin
                            nxt_st.group_a_irq_enable = wd[0];
                        end
                        if (wd[3:1] == 3'(PPC_PC_ACK_A)) begin
                            nxt_st.bidir_output_irq_enable = wd[0];
                        end
                        if (wd[3:1] == 3'(PPC_PC_HS_B)) begin
                            nxt_st.group_b_irq_enable = wd[0];
                        end
                    end
                end
                PPC_ADR_IRQ_CLR: nxt_st.irq_stat = st_ff.irq_stat & ~wd[1:0];
                PPC_ADR_IRQ_EN: nxt_st.irq_en = wd[1:0];
                default: nxt_st.irq_en = st_ff.irq_en;
            endcase
        end

        // mode 1 input uses the enable at PC4, output the one at PC6
        if (a_m2) begin
            nxt_st.group_a_irq_request = (st_ff.bidir_output_irq_enable & st_ff.group_a_output_full_n)
                | (st_ff.group_a_irq_enable & st_ff.group_a_input_full);
        end else if (a_m1 && a_in) begin
            nxt_st.group_a_irq_request = st_ff.group_a_irq_enable & st_ff.group_a_input_full
                & input_strobe_n_a[PPC_PC_STROBE_A];
        end else if (a_m1) begin
            nxt_st.group_a_irq_request = st_ff.bidir_output_irq_enable & st_ff.group_a_output_full_n
                & pc_s[PPC_PC_ACK_A];
        end else begin
            nxt_st.group_a_irq_request = 1'b0;
        end
        if (b_m1) begin
            nxt_st.group_b_irq_request = st_ff.group_b_irq_enable & pc_s[PPC_PC_HS_B]
                & (b_in ? st_ff.group_b_input_full : st_ff.group_b_output_full_n);
        end else begin
            nxt_st.group_b_irq_request = 1'b0;
        end

        // sticky events: set wins over a same-cycle clear
        if (nxt_st.group_a_irq_request && !st_ff.group_a_irq_request) begin
            nxt_st.irq_stat[PPC_IRQ_BIT_A] = 1'b1;
        end
        if (nxt_st.group_b_irq_request && !st_ff.group_b_irq_request) begin
            nxt_st.irq_stat[PPC_IRQ_BIT_B] = 1'b1;
        end
        nxt_st.irq = |(st_ff.irq_stat & st_ff.irq_en);

        // reset pin: count the synchronised high level, act once the count reaches the limit
        if (reset_pin) begin
            if (st_ff.rst_cnt != PPC_RST_CNT_MAX) begin
                nxt_st.rst_cnt = st_ff.rst_cnt + 7'h01;
            end
        end else begin
            nxt_st.rst_cnt = 7'h00;
        end
        if (reset_pin && st_ff.rst_cnt >= PPC_RST_CNT_MAX - 7'h01) begin
            nxt_st.mode = PPC_MODE_RST;
            nxt_st.out_a = 8'h00;
            nxt_st.out_b = 8'h00;
            nxt_st.out_c = 8'h00;
            nxt_st.group_a_input_full = 1'b0;
            nxt_st.group_b_input_full = 1'b0;
            nxt_st.group_a_output_full_n = 1'b1;
            nxt_st.group_b_output_full_n = 1'b1;
            nxt_st.group_a_irq_enable = 1'b0;
            nxt_st.bidir_output_irq_enable = 1'b0;
            nxt_st.group_b_irq_enable = 1'b0;
        end

        // pin drivers, registered from current state
        nxt_st.pa_o = st_ff.out_a;
        nxt_st.pa_oe = (a_m2 ? pc_s[PPC_PC_ACK_A] : a_in) ? 8'h00 : 8'hFF;
        nxt_st.pb_o = st_ff.out_b;
        nxt_st.pb_oe = b_in ? 8'h00 : 8'hFF;
        nxt_st.pc_o = st_ff.out_c;
        nxt_st.pc_oe = {st_ff.mode[PPC_PCU_IN] ? 4'h0 : 4'hF, st_ff.mode[PPC_PCL_IN] ? 4'h0 : 4'hF};
        if (a_hs) begin
            nxt_st.pc_o[PPC_PC_IRQ_A] = st_ff.group_a_irq_request;
            nxt_st.pc_oe[PPC_PC_IRQ_A] = 1'b1;
            if (a_m2 || a_in) begin
                nxt_st.pc_o[PPC_PC_INFULL_A] = st_ff.group_a_input_full;
                nxt_st.pc_oe[PPC_PC_INFULL_A] = 1'b1;
                nxt_st.pc_oe[PPC_PC_STROBE_A] = 1'b0;
            end
            if (a_m2 || !a_in) begin
                nxt_st.pc_o[PPC_PC_OUTFULL_A] = st_ff.group_a_output_full_n;
                nxt_st.pc_oe[PPC_PC_OUTFULL_A] = 1'b1;
                nxt_st.pc_oe[PPC_PC_ACK_A] = 1'b0;
            end
        end
        if (b_m1) begin
            nxt_st.pc_o[PPC_PC_IRQ_B] = st_ff.group_b_irq_request;
            nxt_st.pc_o[PPC_PC_FULL_B] = b_in ? st_ff.group_b_input_full : st_ff.group_b_output_full_n;
            nxt_st.pc_oe[PPC_PC_IRQ_B] = 1'b1;
            nxt_st.pc_oe[PPC_PC_FULL_B] = 1'b1;
            nxt_st.pc_oe[PPC_PC_HS_B] = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            st_ff <= '0;
            st_ff.mode <= PPC_MODE_RST;
            st_ff.group_a_output_full_n <= 1'b1;
            st_ff.group_b_output_full_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign WB_DAT_O = st_ff.dat;
    assign WB_ACK_O = st_ff.ack;
    assign PA_O = st_ff.pa_o;
    assign PA_OE = st_ff.pa_oe;
    assign PB_O = st_ff.pb_o;
    assign PB_OE = st_ff.pb_oe;
    assign PC_O = st_ff.pc_o;
    assign PC_OE = st_ff.pc_oe;
    assign IRQ = st_ff.irq;
endmodule : ppc_port

//--- common/ppc_pkg.sv
/*
 * ppc_pkg: register map, mode word fields, port C pin positions and
 * timing counts of the parallel port block.
 * assumes a 125 MHz REF_CLK and a 32-bit classic Wishbone register bus.
 */
package ppc_pkg;
    localparam int PPC_AW = 8;
    // byte offsets, one aligned word each
    localparam logic [7:0] PPC_ADR_PORT_A = 8'h00;
    localparam logic [7:0] PPC_ADR_PORT_B = 8'h04;
    localparam logic [7:0] PPC_ADR_PORT_C = 8'h08;
    localparam logic [7:0] PPC_ADR_CMD = 8'h0C;
    localparam logic [7:0] PPC_ADR_IRQ_STAT = 8'h10;
    localparam logic [7:0] PPC_ADR_IRQ_CLR = 8'h14;
    localparam logic [7:0] PPC_ADR_IRQ_EN = 8'h18;
    // mode word: all ports input, mode 0
    localparam logic [7:0] PPC_MODE_RST = 8'h9B;
    localparam int PPC_CMD_SEL = 7;
    localparam int PPC_GA_M2 = 6;
    localparam int PPC_GA_M1 = 5;
    localparam int PPC_PA_IN = 4;
    localparam int PPC_PCU_IN = 3;
    localparam int PPC_GB_M1 = 2;
    localparam int PPC_PB_IN = 1;
    localparam int PPC_PCL_IN = 0;
    // port C handshake pin positions
    localparam int PPC_PC_OUTFULL_A = 7;
    localparam int PPC_PC_ACK_A = 6;
    localparam int PPC_PC_INFULL_A = 5;
    localparam int PPC_PC_STROBE_A = 4;
    localparam int PPC_PC_IRQ_A = 3;
    localparam int PPC_PC_HS_B = 2;
    localparam int PPC_PC_FULL_B = 1;
    localparam int PPC_PC_IRQ_B = 0;
    // interrupt status bits
    localparam int PPC_IRQ_BIT_A = 0;
    localparam int PPC_IRQ_BIT_B = 1;
    // timing
    localparam int PPC_CLK_PERIOD_NS = 8;
    localparam int PPC_RST_PULSE_NS = 500;
    // strictly longer than the pulse time
    localparam int PPC_RST_PULSE_CYC = PPC_RST_PULSE_NS / PPC_CLK_PERIOD_NS + 1;
    localparam logic [6:0] PPC_RST_CNT_MAX = 7'(PPC_RST_PULSE_CYC);
endpackage : ppc_pkg

//--- hdl/ppc_sync3.sv
/*
 * ppc_sync3: three-stage synchroniser for the 25 pin inputs.
 * assumes inputs are asynchronous to clk; q changes only once
 * stages two and three agree.
 */
module ppc_sync3 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [24:0] d,
    output logic [24:0] q
);
    typedef struct packed {
        logic [24:0] s1;
        logic [24:0] s2;
        logic [24:0] s3;
        logic [24:0] q;
    } ppc_sync_t;

    ppc_sync_t st_ff;
    ppc_sync_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // first stage is read only by the second
        for (int i = 0; i < 25; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;
endmodule : ppc_sync3

//--- verif/ppc_pin_model.sv
/* ppc_pin_model: peripheral on the port pins, drives data and low strobe or ack pulses.
   assumes its task is entered just after a rising edge of clk. */
module ppc_pin_model (
    input wire logic clk,
    output logic [7:0] pa,
    output logic [7:0] pb,
    output logic [7:0] pc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hold = 1'b0;
    logic [7:0] dat = 8'h00;
    // strobe and ack pins idle high
    initial begin
        pa = 8'h5A;
        pb = 8'hA5;
        pc = 8'hFF;
    end
    // a released data bus keeps moving so a stale value never reads as good
    always @(posedge clk) begin
        pa <= hold ? dat : ~pa;
        pb <= hold ? dat : ~pb;
    end
    // data is set up before the falling edge and held past the rising edge
    task automatic pulse(input int pin, input logic [7:0] d);
        hold <= 1'b1;
        dat <= d;
        repeat (3) @(posedge clk);
        pc[pin] <= 1'b0;
        repeat (4) @(posedge clk);
        pc[pin] <= 1'b1;
        repeat (2) @(posedge clk);
        hold <= 1'b0;
    endtask : pulse
endmodule : ppc_pin_model

//--- verif/ppc_port_sva.sv
/* ppc_port_chk: concurrent checks on the ports of ppc_port.
   assumes REF_CLK only; mode is tracked from command writes, not from pin reset. */
module ppc_port_chk
    import ppc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [PPC_AW-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [7:0] PC_I,
    input wire logic [7:0] PA_O,
    input wire logic [7:0] PA_OE,
    input wire logic [7:0] PB_O,
    input wire logic [7:0] PB_OE,
    input wire logic [7:0] PC_O,
    input wire logic [7:0] PC_OE,
    input wire logic PORT_RESET,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    logic take;
    logic mode_wr;
    logic a_in;
    logic a_out;
    logic [7:0] mode_ff;
    logic [6:0] hi_cnt_ff;
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign mode_wr = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == PPC_ADR_CMD && WB_DAT_I[7];
    assign a_in = mode_ff[5] && !mode_ff[6] && mode_ff[4];
    assign a_out = mode_ff[5] && !mode_ff[6] && !mode_ff[4];
    // counter instead of a long repetition, which the tools would unroll
    always_ff @(posedge REF_CLK) begin
        if (!RST_B)
            mode_ff <= PPC_MODE_RST;
        else if (mode_wr)
            mode_ff <= WB_DAT_I[7:0];
        if (!PORT_RESET)
            hi_cnt_ff <= 7'h00;
        else if (hi_cnt_ff != 7'h7F)
            hi_cnt_ff <= hi_cnt_ff + 7'h01;
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);
    a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    a_ack_after_take: assert property (take |=> WB_ACK_O) else $error("ack missing after request");
    a_reset_pins_idle: assert property (disable iff (1'b0) !RST_B |=> PA_OE == 8'h00 && PB_OE == 8'h00
        && PC_OE == 8'h00 && !IRQ) else $error("pins driven in reset");
    a_unmapped_reads_zero: assert property (take && !WB_WE_I && WB_ADR_I > PPC_ADR_IRQ_EN |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_cmd_clears_a: assert property (mode_wr |-> ##2 PA_O == 8'h00) else $error("port a not cleared");
    a_cmd_keeps_b: assert property (mode_wr |-> ##2 $stable(PB_O)) else $error("port b changed");
    a_pin_reset_inputs: assert property (hi_cnt_ff == 7'h4B |-> PA_OE == 8'h00 && PB_OE == 8'h00
        && PC_OE == 8'h00) else $error("long pin reset left outputs");
    a_in_full_set: assert property (a_in && $fell(PC_I[PPC_PC_STROBE_A])
        |-> ##[2:8] PC_O[PPC_PC_INFULL_A]) else $error("input full not set");
    a_in_full_clear: assert property (a_in && take && !WB_WE_I && WB_ADR_I == PPC_ADR_PORT_A
        |-> ##2 !PC_O[PPC_PC_INFULL_A]) else $error("input full not cleared");
    a_out_full_low: assert property (a_out && take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == PPC_ADR_PORT_A
        |-> ##2 !PC_O[PPC_PC_OUTFULL_A]) else $error("output full not low");
    a_out_full_high: assert property (a_out && $fell(PC_I[PPC_PC_ACK_A])
        |-> ##[2:8] PC_O[PPC_PC_OUTFULL_A]) else $error("output full not released");
    c_mode_write: cover property (mode_wr);
    c_long_reset: cover property (hi_cnt_ff == 7'h4B);
    c_strobe_in: cover property (a_in && $fell(PC_I[PPC_PC_STROBE_A]));
endmodule : ppc_port_chk
bind ppc_port ppc_port_chk chk_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .PC_I(PC_I), .PA_O(PA_O), .PA_OE(PA_OE), .PB_O(PB_O), .PB_OE(PB_OE), .PC_O(PC_O),
    .PC_OE(PC_OE), .PORT_RESET(PORT_RESET), .IRQ(IRQ));

//--- verif/test_ppc_port.sv
/* test_ppc_port: self-checking bench for ppc_port with a pin-side peripheral model.
   assumes the one-cycle Wishbone answer and 3-4 cycle pin synchroniser of the design. */
module test_ppc_port;
    timeunit 1ns;
    timeprecision 1ps;
    import ppc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [PPC_AW-1:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic port_reset = 1'b1;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic [7:0] pa_i, pb_i, pc_i, pa_o, pa_oe, pb_o, pb_oe, pc_o, pc_oe, q, da, db;
    int fail_count = 0;
    int compares = 0;
    initial forever #4 ref_clk = ~ref_clk;
    ppc_port dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PA_I(pa_i),
        .PA_O(pa_o), .PA_OE(pa_oe), .PB_I(pb_i), .PB_O(pb_o), .PB_OE(pb_oe), .PC_I(pc_i), .PC_O(pc_o),
        .PC_OE(pc_oe), .PORT_RESET(port_reset), .IRQ(irq));
    ppc_pin_model prt_u (.clk(ref_clk), .pa(pa_i), .pb(pb_i), .pc(pc_i));
    task automatic print_verdict;
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got, input logic [7:0] mask);
        compares++;
        if (((got ^ exp) & mask) !== 8'h00) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp & mask, got & mask);
        end
    endtask : check
    // request held until ack is sampled; no latency assumed beyond the bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40) begin
            fail_count++;
            print_verdict();
        end
        @(posedge ref_clk);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
        wb(1'b0, a, 8'h00);
        check(what, exp, q, mask);
    endtask : rdc
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle
    initial begin
        void'($urandom(91064));
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        idle(6300);
        port_reset <= 1'b0;
        idle(8);
        rdc("mode word", PPC_ADR_CMD, PPC_MODE_RST, 8'hFF);
        rdc("unmapped", 8'h1C, 8'h00, 8'hFF);
        check("oe idle", 8'h00, pa_oe | pb_oe | pc_oe, 8'hFF);
        wr(PPC_ADR_CMD, 8'h80);
        da = 8'($urandom);
        db = 8'($urandom);
        wr(PPC_ADR_PORT_A, da);
        wr(PPC_ADR_PORT_B, db);
        idle(2);
        check("port a pins", da, pa_o, 8'hFF);
        // both groups to mode 1 output
        wr(PPC_ADR_CMD, 8'hA4);
        idle(2);
        check("port a cleared", 8'h00, pa_o, 8'hFF);
        check("port b kept", db, pb_o, 8'hFF);
        wr(PPC_ADR_CMD, 8'h0D);
        wr(PPC_ADR_CMD, 8'h05);
        rdc("status out idle", PPC_ADR_PORT_C, 8'hC6, 8'hC6);
        wr(PPC_ADR_PORT_A, da);
        wr(PPC_ADR_PORT_B, db);
        rdc("status out full", PPC_ADR_PORT_C, 8'h44, 8'hCF);
        prt_u.pulse(PPC_PC_ACK_A, 8'h00);
        prt_u.pulse(PPC_PC_HS_B, 8'h00);
        idle(8);
        rdc("status out acked", PPC_ADR_PORT_C, 8'hCF, 8'hCF);
        rdc("irq status", PPC_ADR_IRQ_STAT, 8'h03, 8'h03);
        wr(PPC_ADR_IRQ_EN, 8'h01);
        idle(2);
        check("irq on", 8'h01, {7'h00, irq}, 8'h01);
        wr(PPC_ADR_IRQ_EN, 8'h00);
        idle(2);
        check("irq masked", 8'h00, {7'h00, irq}, 8'h01);
        wr(PPC_ADR_IRQ_CLR, 8'h03);
        wr(PPC_ADR_IRQ_EN, 8'h03);
        rdc("irq cleared", PPC_ADR_IRQ_STAT, 8'h00, 8'h03);
        check("irq off", 8'h00, {7'h00, irq}, 8'h01);
        // both groups to mode 1 input, enables set by bit set
        wr(PPC_ADR_CMD, 8'hBF);
        wr(PPC_ADR_CMD, 8'h09);
        wr(PPC_ADR_CMD, 8'h05);
        rdc("status in idle", PPC_ADR_PORT_C, 8'h14, 8'h3F);
        for (int i = 0; i < 3; i++) begin
            da = 8'($urandom);
            db = 8'($urandom);
            prt_u.pulse(PPC_PC_STROBE_A, da);
            prt_u.pulse(PPC_PC_HS_B, db);
            idle(8);
            rdc("status in full", PPC_ADR_PORT_C, 8'h3F, 8'h3F);
            rdc("port a latch", PPC_ADR_PORT_A, da, 8'hFF);
            rdc("port b latch", PPC_ADR_PORT_B, db, 8'hFF);
            rdc("status in read", PPC_ADR_PORT_C, 8'h14, 8'h3F);
        end
        // enable reset: flag still sets but no request
        wr(PPC_ADR_CMD, 8'h08);
        prt_u.pulse(PPC_PC_STROBE_A, da);
        idle(8);
        rdc("status in masked", PPC_ADR_PORT_C, 8'h20, 8'h38);
        wr(PPC_ADR_CMD, 8'hC0);
        wr(PPC_ADR_CMD, 8'h09);
        wr(PPC_ADR_CMD, 8'h0D);
        rdc("status bidir idle", PPC_ADR_PORT_C, 8'hD0, 8'hF0);
        wr(PPC_ADR_PORT_A, da);
        prt_u.pulse(PPC_PC_STROBE_A, db);
        idle(8);
        rdc("status bidir full", PPC_ADR_PORT_C, 8'h78, 8'hF8);
        port_reset <= 1'b1;
        idle(20);
        port_reset <= 1'b0;
        idle(8);
        rdc("short reset", PPC_ADR_CMD, 8'hC0, 8'hFF);
        port_reset <= 1'b1;
        idle(80);
        port_reset <= 1'b0;
        idle(8);
        rdc("long reset", PPC_ADR_CMD, PPC_MODE_RST, 8'hFF);
        check("oe after reset", 8'h00, pa_oe | pb_oe | pc_oe, 8'hFF);
        print_verdict();
    end
endmodule : test_ppc_port
